// *** hw/fsp_pkg.sv ***
// Purpose: Shared constants and types for the field store with postincrement.
// Assumes: 16-bit memory words, 32-bit bit addresses, one register file bit.
// Notes:   Field size codes use zero to mean a 32-bit field.
package fsp_pkg;

  // ----------------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------------
  localparam int OP_HI = 15;
  localparam int OP_LO = 10;
  localparam logic [5:0] OP_STORE_POSTINC = 6'h24;
  localparam int SEL_BIT = 9;
  localparam int SRC_HI = 8;
  localparam int SRC_LO = 5;
  localparam int FILE_BIT = 4;
  localparam int DST_HI = 3;
  localparam int DST_LO = 0;

  // ----------------------------------------------------------------------
  // Memory and field layout
  // ----------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int OFS_W = 4;
  localparam int SPAN_W = 48;
  localparam logic [5:0] FIELD_MAX = 6'h20;
  localparam logic [4:0] FS_CODE_MAX = 5'h00;
  localparam logic [WORD_W-1:0] WORD_ALL = 16'hFFFF;

  typedef enum {
    FSP_IDLE,
    FSP_LOAD,
    FSP_READ,
    FSP_WRITE,
    FSP_UPDATE
  } fsp_state_e;

endpackage

// *** hw/fsp_merge.sv ***
// Purpose: Merges the low word of a shifted field into one memory word.
// Assumes: Data bits outside the mask are zero.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module fsp_merge
  import fsp_pkg::*;
(
  // Field slice
  input wire logic [WORD_W-1:0] fieldData,
  input wire logic [WORD_W-1:0] fieldMask,
  // Memory word
  input wire logic [WORD_W-1:0] oldWord,
  output logic [WORD_W-1:0] newWord,
  output logic wholeWord
);

  assign newWord = (oldWord & ~fieldMask) | (fieldData & fieldMask);
  assign wholeWord = (fieldMask == WORD_ALL);

endmodule

// *** hw/fsp_exec.sv ***
// Purpose: Executes the store-field-with-postincrement instruction.
// Assumes: Register file reads return data in the same cycle as the index.
// Notes:   Partial words are read, merged and written back.
`timescale 1ns/1ps

module fsp_exec
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Instruction
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  output logic instrDone,
  output logic instrForeign,
  // Field sizes from the field_config_instruction
  input wire logic [4:0] fieldSizeFirst,
  input wire logic [4:0] fieldSizeSecond,
  // Register file
  output logic [4:0] srcRegIdx,
  output logic [4:0] dstRegIdx,
  input wire logic [31:0] srcRegData,
  input wire logic [31:0] dstRegData,
  output logic regWe,
  output logic [4:0] regWrIdx,
  output logic [31:0] regWrData,
  // Memory
  output logic memReq,
  output logic memWe,
  output logic [27:0] memAddr,
  output logic [WORD_W-1:0] memWdata,
  input wire logic [WORD_W-1:0] memRdata,
  input wire logic memAck
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    fsp_state_e st;
    logic sel;
    logic [4:0] srcIdx;
    logic [4:0] dstIdx;
    logic [31:0] ptr;
    logic [5:0] size;
    logic [SPAN_W-1:0] data;
    logic [SPAN_W-1:0] mask;
    logic [27:0] addr;
    logic req;
    logic we;
    logic [WORD_W-1:0] wdata;
    logic regWe;
    logic [31:0] regWrData;
    logic ready;
    logic done;
    logic foreign;
  } fsp_regs_s;

  fsp_regs_s s_r;
  fsp_regs_s s_nxt;

  logic [4:0] selCode;
  logic [5:0] selSize;
  logic [31:0] fieldMask32;
  logic [WORD_W-1:0] mergedWord;
  logic wholeWord;
  logic [SPAN_W-1:0] maskLeft;

  // ----------------------------------------------------------------------
  // Field size and mask
  // ----------------------------------------------------------------------
  assign selCode = s_r.sel ? fieldSizeSecond : fieldSizeFirst;
  assign selSize = (selCode == FS_CODE_MAX) ? FIELD_MAX
                                            : {1'b0, selCode};
  assign fieldMask32 = (selSize == FIELD_MAX) ? 32'hFFFFFFFF
                     : ((32'h00000001 << selSize) - 32'h00000001);
  assign maskLeft = s_r.mask >> WORD_W;

  fsp_merge u_merge (
    .fieldData(s_r.data[WORD_W-1:0]),
    .fieldMask(s_r.mask[WORD_W-1:0]),
    .oldWord(memRdata),
    .newWord(mergedWord),
    .wholeWord(wholeWord)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.regWe = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.foreign = 1'b0;
    unique case (s_r.st)
      FSP_IDLE: begin
        if (instrValid && s_r.ready) begin
          if (instrWord[OP_HI:OP_LO] == OP_STORE_POSTINC) begin
            s_nxt.ready = 1'b0;
            s_nxt.sel = instrWord[SEL_BIT];
            // One file bit serves both operands.
            s_nxt.srcIdx = {instrWord[FILE_BIT],
                            instrWord[SRC_HI:SRC_LO]};
            s_nxt.dstIdx = {instrWord[FILE_BIT],
                            instrWord[DST_HI:DST_LO]};
            s_nxt.st = FSP_LOAD;
          end else begin
            s_nxt.foreign = 1'b1;
          end
        end
      end
      FSP_LOAD: begin
        s_nxt.size = selSize;
        s_nxt.ptr = dstRegData;
        s_nxt.addr = dstRegData[31:OFS_W];
        s_nxt.data = {16'h0000, srcRegData & fieldMask32}
                     << dstRegData[OFS_W-1:0];
        s_nxt.mask = {16'h0000, fieldMask32}
                     << dstRegData[OFS_W-1:0];
        s_nxt.st = FSP_READ;
      end
      FSP_READ: begin
        if (!s_r.req) begin
          if (wholeWord) begin
            s_nxt.wdata = s_r.data[WORD_W-1:0];
            s_nxt.req = 1'b1;
            s_nxt.we = 1'b1;
            s_nxt.st = FSP_WRITE;
          end else begin
            s_nxt.req = 1'b1;
            s_nxt.we = 1'b0;
          end
        end else if (memAck) begin
          s_nxt.wdata = mergedWord;
          s_nxt.we = 1'b1;
          s_nxt.st = FSP_WRITE;
        end
      end
      FSP_WRITE: begin
        if (memAck) begin
          s_nxt.req = 1'b0;
          s_nxt.we = 1'b0;
          s_nxt.data = s_r.data >> WORD_W;
          s_nxt.mask = maskLeft;
          s_nxt.addr = s_r.addr + 28'h0000001;
          s_nxt.st = (maskLeft == '0) ? FSP_UPDATE : FSP_READ;
        end
      end
      FSP_UPDATE: begin
        s_nxt.regWe = 1'b1;
        s_nxt.regWrData = s_r.ptr + {26'h0000000, s_r.size};
        s_nxt.done = 1'b1;
        s_nxt.ready = 1'b1;
        s_nxt.st = FSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= FSP_IDLE;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign instrReady = s_r.ready;
  assign instrDone = s_r.done;
  assign instrForeign = s_r.foreign;
  assign srcRegIdx = s_r.srcIdx;
  assign dstRegIdx = s_r.dstIdx;
  assign regWe = s_r.regWe;
  assign regWrIdx = s_r.dstIdx;
  assign regWrData = s_r.regWrData;
  assign memReq = s_r.req;
  assign memWe = s_r.we;
  assign memAddr = s_r.addr;
  assign memWdata = s_r.wdata;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [31:0] ptrHold;
  logic [31:0] srcHold;
  logic [5:0] sizeHold;
  logic firstWord;
  logic [31:0] holdMask32;
  logic [SPAN_W-1:0] srcPlaced;

  // The source field as it should sit across the words it covers.
  assign holdMask32 = (sizeHold == FIELD_MAX) ? 32'hFFFFFFFF
                    : ((32'h00000001 << sizeHold) - 32'h00000001);
  assign srcPlaced = {16'h0000, srcHold & holdMask32} << ptrHold[OFS_W-1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptrHold <= '0;
      srcHold <= '0;
      sizeHold <= '0;
      firstWord <= 1'b0;
    end else if (s_r.st == FSP_LOAD) begin
      ptrHold <= dstRegData;
      srcHold <= srcRegData;
      sizeHold <= selSize;
      firstWord <= 1'b1;
    end else if (s_r.st == FSP_WRITE && memAck) begin
      firstWord <= 1'b0;
    end
  end

  sequence loadStep;
    s_r.st == FSP_LOAD;
  endsequence

  sequence readDone;
    s_r.st == FSP_READ && s_r.req && memAck;
  endsequence

  chk_size_select: assert property (@(posedge mclk) disable iff (!rst_n)
    loadStep |=> s_r.size == ($past(s_r.sel) ?
      (fieldSizeSecond == FS_CODE_MAX ? FIELD_MAX : {1'b0, fieldSizeSecond}) :
      (fieldSizeFirst == FS_CODE_MAX ? FIELD_MAX : {1'b0, fieldSizeFirst})))
    else $error("field size does not follow selector");

  chk_source_low_bits: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (s_r.st == FSP_WRITE && memAck && firstWord) |->
      (memWdata & s_r.mask[WORD_W-1:0]) ==
      (srcPlaced[WORD_W-1:0] & s_r.mask[WORD_W-1:0]))
    else $error("stored field bits differ from source");

  chk_first_address: assert property (@(posedge mclk) disable iff (!rst_n)
    loadStep |=> memAddr == $past(dstRegData[31:OFS_W]) ##1 memReq)
    else $error("first word address not taken from pointer");

  chk_bit_offset: assert property (@(posedge mclk) disable iff (!rst_n)
    loadStep |=> s_r.mask[0] == ($past(dstRegData[OFS_W-1:0]) == 4'h0))
    else $error("field not placed at bit offset");

  chk_postinc_value: assert property (@(posedge mclk) disable iff (!rst_n)
    regWe |-> regWrData == ptrHold + {26'h0000000, sizeHold} &&
      $past(s_r.st == FSP_WRITE, 2) && instrDone)
    else $error("pointer update wrong or early");

  chk_keep_neighbours: assert property (@(posedge mclk) disable iff (!rst_n)
    readDone |=> memReq && memWe &&
      (memWdata & ~s_r.mask[WORD_W-1:0]) ==
      ($past(memRdata) & ~s_r.mask[WORD_W-1:0]))
    else $error("neighbouring bits disturbed");

endmodule

// *** tb/fsp_mem_model.sv ***
// Purpose: Word memory behind the field store, answering after a set wait.
// Assumes: Sixteen words, indexed by the low word-address bits.
// Notes:   Read data turns over every cycle outside an answer.
`timescale 1ns/1ps
module fsp_mem_model
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [27:0] memAddr,
  input wire logic [WORD_W-1:0] memWdata,
  input wire logic [3:0] ackWait,
  // Answer
  output logic [WORD_W-1:0] memRdata,
  output logic memAck
);
  logic [WORD_W-1:0] mem [16];
  logic [3:0] waitCnt;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 16'h0000;
    end else if (memAck) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= ~memRdata;
    end else if (memReq && waitCnt >= ackWait) begin
      memAck <= 1'b1;
      if (memWe) begin
        mem[memAddr[3:0]] <= memWdata;
      end else begin
        memRdata <= mem[memAddr[3:0]];
      end
    end else begin
      memRdata <= ~memRdata;
      if (memReq) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule

// *** tb/field_store_postincrement_bench.sv ***
// Purpose: Self-checking bench for the field store with postincrement.
// Assumes: Fields lie in the four words from bit address 15500.
// Notes:   Memory words are preset through the model's array.
`timescale 1ns/1ps
module field_store_postincrement_bench
  import fsp_pkg::*;
();
  typedef struct packed {
    logic sel;
    logic [4:0] fsA;
    logic [4:0] fsB;
    logic [31:0] ptr;
    logic [31:0] src;
    logic [15:0] init;
    logic [31:0] newPtr;
  } fsp_row_s;
  localparam fsp_row_s ROWS [9] = '{
    '{1'b1, 5'h03, 5'h08, 32'h15525, 32'hFFFFFFFF, 16'h0000, 32'h1552D},
    '{1'b0, 5'h0D, 5'h05, 32'h15520, 32'hFFFFFFFF, 16'h0000, 32'h1552D},
    '{1'b1, 5'h07, 5'h10, 32'h1551D, 32'hFFFFFFFF, 16'h0000, 32'h1552D},
    '{1'b0, 5'h13, 5'h09, 32'h15516, 32'hFFFFFFFF, 16'h0000, 32'h15529},
    '{1'b1, 5'h02, 5'h18, 32'h15507, 32'hFFFFFFFF, 16'h0000, 32'h1551F},
    '{1'b0, 5'h1B, 5'h06, 32'h15507, 32'hFFFFFFFF, 16'h0000, 32'h15522},
    '{1'b0, 5'h00, 5'h01, 32'h15500, 32'h12345678, 16'hA5A5, 32'h15520},
    '{1'b1, 5'h1F, 5'h01, 32'h1550F, 32'h00000002, 16'h5A5A, 32'h15510},
    '{1'b1, 5'h04, 5'h08, 32'h15504, 32'h12345678, 16'hC3C3, 32'h1550C}
  };
  logic mclk, rst_n, instrValid, instrReady, instrDone, instrForeign;
  logic [15:0] instrWord;
  logic [4:0] fieldSizeFirst, fieldSizeSecond, srcRegIdx, dstRegIdx, regWrIdx;
  logic [31:0] srcRegData, dstRegData, regWrData;
  logic regWe, memReq, memWe, memAck;
  logic [27:0] memAddr;
  logic [WORD_W-1:0] memWdata, memRdata;
  logic [3:0] ackWait;
  logic [31:0] regs [32];
  int fails = 0;
  int checked = 0;

  assign srcRegData = regs[srcRegIdx];
  assign dstRegData = regs[dstRegIdx];

  fsp_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .instrDone(instrDone),
    .instrForeign(instrForeign), .fieldSizeFirst(fieldSizeFirst),
    .fieldSizeSecond(fieldSizeSecond), .srcRegIdx(srcRegIdx),
    .dstRegIdx(dstRegIdx), .srcRegData(srcRegData), .dstRegData(dstRegData),
    .regWe(regWe), .regWrIdx(regWrIdx), .regWrData(regWrData),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck));
  fsp_mem_model mem_u (.mclk(mclk), .rst_n(rst_n), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .ackWait(ackWait), .memRdata(memRdata), .memAck(memAck));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run(input logic [15:0] w);
    int k;
    @(posedge mclk);
    #1;
    instrValid = 1'b1;
    instrWord = w;
    @(posedge mclk);
    #1;
    instrValid = 1'b0;
    for (k = 0; k < 300; k++) begin
      if (instrDone === 1'b1 || instrForeign === 1'b1) break;
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    fsp_row_s r;
    logic [63:0] msk, ex;
    logic [4:0] sz;
    logic f;
    int i, k, n;
    rst_n = 1'b0;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    fieldSizeFirst = 5'h00;
    fieldSizeSecond = 5'h00;
    ackWait = 4'h0;
    repeat (16) @(posedge mclk);
    chk("readyInReset", 4'b1000, {instrReady, memReq, regWe, instrDone});
    #1 rst_n = 1'b1;
    for (i = 0; i < 9; i++) begin
      r = ROWS[i];
      f = i[0];
      ackWait = 4'(i % 3);
      for (k = 0; k < 16; k++) mem_u.mem[k] = r.init;
      for (k = 0; k < 32; k++) regs[k] = ~r.ptr;
      regs[{f, 4'h0}] = r.src;
      regs[{f, 4'h1}] = r.ptr;
      fieldSizeFirst = r.fsA;
      fieldSizeSecond = r.fsB;
      sz = r.sel ? r.fsB : r.fsA;
      n = (sz == 5'h00) ? 32 : int'(sz);
      msk = ((64'h1 << n) - 64'h1) << r.ptr[5:0];
      ex = ({4{r.init}} & ~msk) | (({32'h0, r.src} << r.ptr[5:0]) & msk);
      run({OP_STORE_POSTINC, r.sel, 4'h0, f, 4'h1});
      chk("regWe", 2'b11, {instrDone, regWe});
      chk("regWrIdx", {f, 4'h1}, regWrIdx);
      chk("regIdx", {f, 4'h0, f, 4'h1}, {srcRegIdx, dstRegIdx});
      chk("regWrData", r.newPtr, regWrData);
      chk("memory", ex, {mem_u.mem[3], mem_u.mem[2], mem_u.mem[1],
        mem_u.mem[0]});
    end
    // Another opcode is consumed without memory or register traffic.
    run(16'h8000);
    chk("foreign", 2'b10, {instrForeign, regWe});
    chk("foreignMem", ex, {mem_u.mem[3], mem_u.mem[2],
      mem_u.mem[1], mem_u.mem[0]});
    // Reset in mid-store, then a store must still complete.
    ackWait = 4'h5;
    regs[{1'b1, 4'h1}] = 32'h15505;
    @(posedge mclk);
    #1;
    instrValid = 1'b1;
    instrWord = {OP_STORE_POSTINC, 1'b0, 4'h0, 1'b1, 4'h1};
    repeat (4) @(posedge mclk);
    #1;
    instrValid = 1'b0;
    rst_n = 1'b0;
    #1;
    chk("midReset", 4'b1000, {instrReady, memReq, regWe, instrDone});
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    run({OP_STORE_POSTINC, 1'b0, 4'h0, 1'b1, 4'h1});
    chk("afterReset", 32'h15509, regWrData);
    results();
  end
endmodule
